// file: src/samd_decoder.sv
// Functional notes
// - accepts word, halfword and byte accesses
// - lanes and data steered little endian
// - fixed 4 GB map, not relocatable
// - reserved addresses fault and reach no slave
// - 0x2200_0000..0x2201_FFFF alias SRAM bits at 0x2000_0000
// - 0x4200_0000..0x43FF_FFFF alias peripheral bits 0x4000_0000..0x400F_FFFF
// - system peripheral block selected at 0xE000_E000..0xE000_EFFF
// - Normal regions may be reordered or read speculatively
// - Device accesses keep order against Device and Strongly Ordered
// - Strongly Ordered accesses keep order against everything
// - Device writes may buffer, Strongly Ordered writes never
// - execute-never blocks fetches; rsp_xn_fault only on execution
// - Device/Strongly Ordered pair observed in program order
// - code region Normal, executable
// - SRAM region Normal, executable
// - peripheral region Device, execute-never
// - external device region Device, execute-never
// - private peripheral range Strongly Ordered, execute-never; above reserved
// - discarded prefetches are tolerated without side effects
// - alias word = base + byte offset*32 + bit*4
// - alias write sets/clears one bit from bit 0; read gives 0/1
module samd_decoder
   import samd_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // core side request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_fetch,
   input  wire logic        req_exec,
   input  wire logic        req_write,
   input  wire samd_size_t  req_size,
   input  wire logic [31:0] req_addr,
   input  wire logic [31:0] req_wdata,
   // core side response
   output logic             rsp_valid,
   output logic             rsp_fault,
   output logic             rsp_xn_fault,
   output logic [31:0]      rsp_rdata,
   // slave side
   output samd_slave_t      sl_sel,
   output samd_mtype_t      sl_mtype,
   output logic             sl_xn,
   output logic             sl_bufferable,
   output logic             sl_valid,
   output logic             sl_write,
   output logic [31:0]      sl_addr,
   output logic [3:0]       sl_lanes,
   output logic [31:0]      sl_wdata,
   input  wire logic        sl_done,
   input  wire logic [31:0] sl_rdata
);
   // ****************************************************************
   // decode
   // ****************************************************************
   samd_slave_t dec_slave;
   samd_mtype_t dec_mtype;
   logic        dec_xn;
   logic        dec_alias;
   logic        dec_aperi;
   logic [31:0] al_addr;
   logic [4:0]  al_bit;

   samd_region u_region (
      .addr       (req_addr),
      .slave      (dec_slave),
      .mtype      (dec_mtype),
      .xn         (dec_xn),
      .alias_hit  (dec_alias),
      .alias_peri (dec_aperi)
   );

   samd_alias u_alias (
      .addr      (req_addr),
      .peri      (dec_aperi),
      .word_addr (al_addr),
      .bit_pos   (al_bit)
   );

   // ****************************************************************
   // transfer sequencer
   // ****************************************************************
   samd_state_t st_reg,    st_next;
   samd_slave_t sel_reg,   sel_next;
   samd_mtype_t mt_reg,    mt_next;
   logic        xn_reg,    xn_next;
   logic        wr_reg,    wr_next;
   logic        al_reg,    al_next;
   logic [4:0]  bit_reg,   bit_next;
   logic        bval_reg,  bval_next;
   logic [31:0] addr_reg,  addr_next;
   logic [3:0]  lane_reg,  lane_next;
   logic [31:0] wd_reg,    wd_next;
   logic        rv_reg,    rv_next;
   logic        rf_reg,    rf_next;
   logic        rx_reg,    rx_next;
   logic [31:0] rd_reg,    rd_next;
   logic        accept;
   logic [31:0] rmw_word;

   // one access at a time, so every access completes in program order
   assign req_ready = (st_reg == SAMD_ST_IDLE);
   assign accept    = req_valid && req_ready;
   assign rmw_word  = (sl_rdata & ~(32'h0000_0001 << bit_reg))
                    | ({31'h0000_0000, bval_reg} << bit_reg);

   always_comb begin
      st_next   = st_reg;
      sel_next  = sel_reg;
      mt_next   = mt_reg;
      xn_next   = xn_reg;
      wr_next   = wr_reg;
      al_next   = al_reg;
      bit_next  = bit_reg;
      bval_next = bval_reg;
      addr_next = addr_reg;
      lane_next = lane_reg;
      wd_next   = wd_reg;
      rv_next   = 1'b0;
      rf_next   = 1'b0;
      rx_next   = 1'b0;
      rd_next   = rd_reg;
      case (st_reg)
         SAMD_ST_IDLE: begin
            if (accept) begin
               if (dec_slave == SAMD_SL_NONE) begin
                  rv_next = 1'b1;
                  rf_next = 1'b1;
               end else if (req_fetch && (dec_xn || (dec_alias && dec_aperi))) begin
                  // blocked fetch: rsp_fault always flagged, rsp_xn_fault only if it is executed
                  rv_next = 1'b1;
                  rf_next = 1'b1;
                  rx_next = req_exec;
               end else begin
                  sel_next  = dec_slave;
                  mt_next   = dec_mtype;
                  xn_next   = dec_xn;
                  wr_next   = req_write;
                  // fetches from the SRAM alias are not remapped
                  al_next   = dec_alias && !req_fetch;
                  bit_next  = al_bit;
                  bval_next = req_wdata[0];
                  st_next   = SAMD_ST_RDWT;
                  if (dec_alias && !req_fetch) begin
                     addr_next = al_addr;
                     lane_next = 4'hF;
                     wd_next   = 32'h0000_0000;
                  end else begin
                     addr_next = req_addr;
                     lane_next = samd_lanes(req_size, req_addr[1:0]);
                     // replicate so each lane carries its little-endian byte
                     case (req_size)
                        SAMD_SZ_BYTE: wd_next = {4{req_wdata[7:0]}};
                        SAMD_SZ_HALF: wd_next = {2{req_wdata[15:0]}};
                        default:      wd_next = req_wdata;
                     endcase
                  end
               end
            end
         end
         SAMD_ST_RDWT: begin
            if (sl_done) begin
               if (al_reg && wr_reg) begin
                  // read-modify-write second half
                  wd_next = rmw_word;
                  al_next = 1'b0;
                  st_next = SAMD_ST_WRWT;
               end else begin
                  rv_next = 1'b1;
                  st_next = SAMD_ST_IDLE;
                  if (al_reg) begin
                     rd_next = {31'h0000_0000, sl_rdata[bit_reg]};
                  end else begin
                     rd_next = sl_rdata >> {addr_reg[1:0], 3'h0};
                  end
               end
            end
         end
         SAMD_ST_WRWT: begin
            if (sl_done) begin
               rv_next = 1'b1;
               st_next = SAMD_ST_IDLE;
            end
         end
         default: st_next = SAMD_ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg   <= SAMD_ST_IDLE;
         sel_reg  <= SAMD_SL_NONE;
         mt_reg   <= SAMD_MT_NORMAL;
         xn_reg   <= 1'b0;
         wr_reg   <= 1'b0;
         al_reg   <= 1'b0;
         bit_reg  <= 5'h00;
         bval_reg <= 1'b0;
         addr_reg <= 32'h0000_0000;
         lane_reg <= 4'h0;
         wd_reg   <= 32'h0000_0000;
         rv_reg   <= 1'b0;
         rf_reg   <= 1'b0;
         rx_reg   <= 1'b0;
         rd_reg   <= 32'h0000_0000;
      end else begin
         st_reg   <= st_next;
         sel_reg  <= sel_next;
         mt_reg   <= mt_next;
         xn_reg   <= xn_next;
         wr_reg   <= wr_next;
         al_reg   <= al_next;
         bit_reg  <= bit_next;
         bval_reg <= bval_next;
         addr_reg <= addr_next;
         lane_reg <= lane_next;
         wd_reg   <= wd_next;
         rv_reg   <= rv_next;
         rf_reg   <= rf_next;
         rx_reg   <= rx_next;
         rd_reg   <= rd_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign sl_valid      = (st_reg != SAMD_ST_IDLE);
   assign sl_write      = (st_reg == SAMD_ST_WRWT) || (wr_reg && !al_reg);
   assign sl_sel        = sel_reg;
   assign sl_mtype      = mt_reg;
   assign sl_xn         = xn_reg;
   // normal may be reordered, device may buffer, strong never buffered
   assign sl_bufferable = (mt_reg != SAMD_MT_STRONG);
   assign sl_addr       = addr_reg;
   assign sl_lanes      = lane_reg;
   assign sl_wdata      = wd_reg;
   assign rsp_valid     = rv_reg;
   assign rsp_fault     = rf_reg;
   assign rsp_xn_fault  = rx_reg;
   assign rsp_rdata     = rd_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_resv;
      @(posedge sys_clk) disable iff (rst)
      (accept && dec_slave == SAMD_SL_NONE) |=> rsp_fault && !sl_valid;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved access not faulted");

   property p_strong_nobuf;
      @(posedge sys_clk) disable iff (rst)
      (sl_valid && sl_addr >= SAMD_PPB_BASE) |-> !sl_bufferable;
   endproperty
   a_strong_nobuf: assert property (p_strong_nobuf) else $error("strong write buffered");

   property p_order;
      @(posedge sys_clk) disable iff (rst)
      sl_valid |-> !req_ready;
   endproperty
   a_order: assert property (p_order) else $error("overlapping accesses");

   property p_xn;
      @(posedge sys_clk) disable iff (rst)
      (accept && req_fetch && dec_xn) |=> !sl_valid && rsp_fault && (rsp_xn_fault == $past(req_exec));
   endproperty
   a_xn: assert property (p_xn) else $error("execute-never fetch not blocked");

   property p_sysp;
      @(posedge sys_clk) disable iff (rst)
      (accept && !req_fetch && req_addr >= SAMD_SYSP_BASE && req_addr <= SAMD_SYSP_END)
         |=> sl_sel == SAMD_SL_SYSP && sl_mtype == SAMD_MT_STRONG;
   endproperty
   a_sysp: assert property (p_sysp) else $error("system block not selected");

   property p_peri_attr;
      @(posedge sys_clk) disable iff (rst)
      (accept && !req_fetch && dec_slave != SAMD_SL_NONE && req_addr[31:29] == 3'h2)
         |=> sl_valid && sl_mtype == SAMD_MT_DEVICE && sl_xn;
   endproperty
   a_peri_attr: assert property (p_peri_attr) else $error("peripheral attributes wrong");

   property p_alias_addr;
      @(posedge sys_clk) disable iff (rst)
      (accept && !req_fetch && dec_alias && !dec_aperi)
         |=> sl_addr == SAMD_SRAM_BASE
             + ((($past(req_addr) - SAMD_SALIAS_BASE) >> 5) & 32'hFFFF_FFFC);
   endproperty
   a_alias_addr: assert property (p_alias_addr) else $error("alias address wrong");

   property p_alias_rd;
      @(posedge sys_clk) disable iff (rst)
      (rsp_valid && al_reg) |-> rsp_rdata[31:1] == 31'h0000_0000;
   endproperty
   a_alias_rd: assert property (p_alias_rd) else $error("alias read not 0/1");
endmodule

// file: src/samd_pkg.sv
package samd_pkg;
   // ****************************************************************
   // region bounds
   // ****************************************************************
   localparam logic [31:0] SAMD_FLASH_BASE   = 32'h0000_0000;
   localparam logic [31:0] SAMD_FLASH_END    = 32'h0000_3FFF;
   localparam logic [31:0] SAMD_CODE_END     = 32'h1FFF_FFFF;
   localparam logic [31:0] SAMD_SRAM_BASE    = 32'h2000_0000;
   localparam logic [31:0] SAMD_SRAM_END     = 32'h2000_0FFF;
   localparam logic [31:0] SAMD_SALIAS_BASE  = 32'h2200_0000;
   localparam logic [31:0] SAMD_SALIAS_END   = 32'h2201_FFFF;
   localparam logic [31:0] SAMD_SRAMREG_END  = 32'h3FFF_FFFF;
   localparam logic [31:0] SAMD_PERI_BASE    = 32'h4000_0000;
   localparam logic [31:0] SAMD_PERI_END     = 32'h400F_FFFF;
   localparam logic [31:0] SAMD_PALIAS_BASE  = 32'h4200_0000;
   localparam logic [31:0] SAMD_PALIAS_END   = 32'h43FF_FFFF;
   localparam logic [31:0] SAMD_PERIREG_END  = 32'h5FFF_FFFF;
   localparam logic [31:0] SAMD_XRAM_BASE    = 32'h6000_0000;
   localparam logic [31:0] SAMD_XDEV_BASE    = 32'hA000_0000;
   localparam logic [31:0] SAMD_XDEV_END     = 32'hDFFF_FFFF;
   localparam logic [31:0] SAMD_PPB_BASE     = 32'hE000_0000;
   localparam logic [31:0] SAMD_PPB_DBG_END  = 32'hE000_2FFF;
   localparam logic [31:0] SAMD_SYSP_BASE    = 32'hE000_E000;
   localparam logic [31:0] SAMD_SYSP_END     = 32'hE000_EFFF;
   localparam logic [31:0] SAMD_TPIU_BASE    = 32'hE004_0000;
   localparam logic [31:0] SAMD_TPIU_END     = 32'hE004_0FFF;
   localparam logic [31:0] SAMD_PPB_END      = 32'hE00F_FFFF;
   // alias field positions
   localparam int SAMD_ALIAS_BIT_LSB  = 2;   // word offset x4 picks bit
   localparam int SAMD_ALIAS_BYTE_LSB = 5;   // byte offset x32

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      SAMD_MT_NORMAL = 2'h0,
      SAMD_MT_DEVICE = 2'h1,
      SAMD_MT_STRONG = 2'h2
   } samd_mtype_t;

   typedef enum logic [3:0] {
      SAMD_SL_NONE  = 4'h0,
      SAMD_SL_FLASH = 4'h1,
      SAMD_SL_SRAM  = 4'h2,
      SAMD_SL_PERI  = 4'h3,
      SAMD_SL_XRAM  = 4'h4,
      SAMD_SL_XDEV  = 4'h5,
      SAMD_SL_DEBUG = 4'h6,
      SAMD_SL_SYSP  = 4'h7,
      SAMD_SL_TPIU  = 4'h8
   } samd_slave_t;

   typedef enum logic [1:0] {
      SAMD_SZ_BYTE = 2'h0,
      SAMD_SZ_HALF = 2'h1,
      SAMD_SZ_WORD = 2'h2
   } samd_size_t;

   // one bit changes along idle -> read wait -> write wait; the return to idle from write wait changes two
   typedef enum logic [1:0] {
      SAMD_ST_IDLE  = 2'h0,
      SAMD_ST_RDWT  = 2'h1,
      SAMD_ST_WRWT  = 2'h3
   } samd_state_t;

   // byte lanes, little endian
   function automatic logic [3:0] samd_lanes(input samd_size_t sz, input logic [1:0] a);
      logic [3:0] l;
      l = 4'h0;
      case (sz)
         SAMD_SZ_BYTE: l = 4'h1 << a;
         SAMD_SZ_HALF: l = a[1] ? 4'hC : 4'h3;
         default:      l = 4'hF;
      endcase
      return l;
   endfunction
endpackage

// file: src/samd_region.sv
module samd_region
   import samd_pkg::*;
(
   // address
   input  wire logic [31:0] addr,
   // attributes
   output samd_slave_t      slave,
   output samd_mtype_t      mtype,
   output logic             xn,
   output logic             alias_hit,
   output logic             alias_peri
);
   // fixed decode; nothing software can touch
   always_comb begin
      slave      = SAMD_SL_NONE;
      mtype      = SAMD_MT_NORMAL;
      xn         = 1'b0;
      alias_hit  = 1'b0;
      alias_peri = 1'b0;
      if (addr <= SAMD_CODE_END) begin
         if (addr <= SAMD_FLASH_END) slave = SAMD_SL_FLASH;
      end else if (addr <= SAMD_SRAMREG_END) begin
         if (addr >= SAMD_SRAM_BASE && addr <= SAMD_SRAM_END) begin
            slave = SAMD_SL_SRAM;
         end else if (addr >= SAMD_SALIAS_BASE && addr <= SAMD_SALIAS_END) begin
            slave     = SAMD_SL_SRAM;
            alias_hit = 1'b1;
         end
      end else if (addr <= SAMD_PERIREG_END) begin
         mtype = SAMD_MT_DEVICE;
         xn    = 1'b1;
         if (addr <= SAMD_PERI_END) begin
            slave = SAMD_SL_PERI;
         end else if (addr >= SAMD_PALIAS_BASE && addr <= SAMD_PALIAS_END) begin
            slave      = SAMD_SL_PERI;
            alias_hit  = 1'b1;
            alias_peri = 1'b1;
         end
      end else if (addr < SAMD_XDEV_BASE) begin
         slave = SAMD_SL_XRAM;
      end else if (addr <= SAMD_XDEV_END) begin
         slave = SAMD_SL_XDEV;
         mtype = SAMD_MT_DEVICE;
         xn    = 1'b1;
      end else if (addr <= SAMD_PPB_END) begin
         mtype = SAMD_MT_STRONG;
         xn    = 1'b1;
         if (addr <= SAMD_PPB_DBG_END) begin
            slave = SAMD_SL_DEBUG;
         end else if (addr >= SAMD_SYSP_BASE && addr <= SAMD_SYSP_END) begin
            slave = SAMD_SL_SYSP;
         end else if (addr >= SAMD_TPIU_BASE && addr <= SAMD_TPIU_END) begin
            slave = SAMD_SL_TPIU;
         end
      end
   end
endmodule

// file: src/samd_alias.sv
module samd_alias
   import samd_pkg::*;
(
   // alias address in
   input  wire logic [31:0] addr,
   input  wire logic        peri,
   // target
   output logic [31:0]      word_addr,
   output logic [4:0]       bit_pos
);
   logic [19:0] byte_off;
   logic [2:0]  bit_num;

   // alias = base + byte*32 + bit*4
   always_comb begin
      byte_off  = addr[SAMD_ALIAS_BYTE_LSB +: 20];
      bit_num   = addr[SAMD_ALIAS_BIT_LSB +: 3];
      word_addr = (peri ? SAMD_PERI_BASE : SAMD_SRAM_BASE) | {12'h000, byte_off[19:2], 2'h0};
      bit_pos   = {byte_off[1:0], bit_num};
   end
endmodule

// file: testbench/samd_slave_model.sv
module samd_slave_model
   import samd_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // slave side from the decoder
   input  wire logic        sl_valid,
   input  wire logic        sl_write,
   input  wire logic [31:0] sl_addr,
   input  wire logic [3:0]  sl_lanes,
   input  wire logic [31:0] sl_wdata,
   // wait states chosen by the bench
   input  wire logic [1:0]  stall,
   // answer
   output logic             sl_done,
   output logic [31:0]      sl_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [31:0] mem [64];
   logic [1:0]  wait_cnt;
   logic [31:0] last_rd;
   logic [5:0]  idx;

   assign idx = sl_addr[7:2];

   // one answer per phase, in the order phases arrive
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sl_done <= 1'b0;
         wait_cnt <= 2'h0;
         last_rd <= 32'h0;
         for (int i = 0; i < 64; i++) begin
            mem[i] <= 32'h1234_5600 + 32'(i);
         end
      end else if (sl_valid && !sl_done && wait_cnt == stall) begin
         sl_done <= 1'b1;
         wait_cnt <= 2'h0;
         if (sl_write) begin
            for (int b = 0; b < 4; b++) begin
               if (sl_lanes[b]) begin
                  mem[idx][8*b +: 8] <= sl_wdata[8*b +: 8];
               end
            end
         end else begin
            last_rd <= mem[idx];
         end
      end else begin
         sl_done <= 1'b0;
         wait_cnt <= (sl_valid && !sl_done) ? wait_cnt + 2'h1 : 2'h0;
      end
   end

   // read data only meaningful with done, inverted otherwise
   assign sl_rdata = sl_done ? last_rd : ~last_rd;
endmodule

// file: testbench/system_address_map_decoder_test.sv
module system_address_map_decoder_test
   import samd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [31:0] a;
      logic [1:0]  sz;
      logic        w, f, x, flt, xnf;
      logic [3:0]  sel;
      logic [1:0]  mt;
      logic        xn;
      logic [3:0]  ln;
   } samd_row_t;

   logic sys_clk, rst, req_valid, req_ready, req_fetch, req_exec, req_write;
   samd_size_t req_size;
   logic [31:0] req_addr, req_wdata, rsp_rdata, sl_addr, sl_wdata, sl_rdata;
   logic rsp_valid, rsp_fault, rsp_xn_fault, sl_xn, sl_bufferable, sl_valid, sl_write, sl_done;
   samd_slave_t sl_sel;
   samd_mtype_t sl_mtype;
   logic [3:0] sl_lanes;
   logic [1:0] stall;
   int bad_count, checks, cycles;
   logic got_fault, got_xnf, got_xn, got_buf, got_wr, saw_sl;
   logic [31:0] got_sel, got_mt, got_ln, got_saddr, got_rd, got_wd;
   samd_row_t r;

   // ****************************************************************
   // plain accesses: inputs beside expected attributes
   // ****************************************************************
   samd_row_t rows [14] = '{
      '{32'h0000_0010, 2'h2, 0, 0, 0, 0, 0, 4'h1, 2'h0, 0, 4'hF},
      '{32'h0000_0000, 2'h2, 0, 1, 1, 0, 0, 4'h1, 2'h0, 0, 4'hF},
      '{32'h0000_4000, 2'h2, 0, 0, 0, 1, 0, 4'h0, 2'h0, 0, 4'h0},
      '{32'h2000_000E, 2'h1, 0, 0, 0, 0, 0, 4'h2, 2'h0, 0, 4'hC},
      '{32'h2000_0013, 2'h0, 1, 0, 0, 0, 0, 4'h2, 2'h0, 0, 4'h8},
      '{32'h2000_1000, 2'h2, 0, 0, 0, 1, 0, 4'h0, 2'h0, 0, 4'h0},
      '{32'h4000_0004, 2'h2, 0, 0, 0, 0, 0, 4'h3, 2'h1, 1, 4'hF},
      '{32'h6000_0000, 2'h2, 0, 0, 0, 0, 0, 4'h4, 2'h0, 0, 4'hF},
      '{32'hA000_0040, 2'h2, 1, 0, 0, 0, 0, 4'h5, 2'h1, 1, 4'hF},
      '{32'hE000_E010, 2'h2, 1, 0, 0, 0, 0, 4'h7, 2'h2, 1, 4'hF},
      '{32'hE004_0000, 2'h2, 0, 0, 0, 0, 0, 4'h8, 2'h2, 1, 4'hF},
      '{32'hE010_0000, 2'h2, 0, 0, 0, 1, 0, 4'h0, 2'h0, 0, 4'h0},
      '{32'h4000_0000, 2'h2, 0, 1, 1, 1, 1, 4'h0, 2'h0, 0, 4'h0},
      '{32'h4000_0000, 2'h2, 0, 1, 0, 1, 0, 4'h0, 2'h0, 0, 4'h0}
   };

   samd_decoder samd_decoder_inst (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_fetch(req_fetch), .req_exec(req_exec),
      .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_fault(rsp_fault),
      .rsp_xn_fault(rsp_xn_fault), .rsp_rdata(rsp_rdata), .sl_sel(sl_sel),
      .sl_mtype(sl_mtype), .sl_xn(sl_xn), .sl_bufferable(sl_bufferable),
      .sl_valid(sl_valid), .sl_write(sl_write), .sl_addr(sl_addr), .sl_lanes(sl_lanes),
      .sl_wdata(sl_wdata), .sl_done(sl_done), .sl_rdata(sl_rdata));

   samd_slave_model samd_slave_model_inst (.sys_clk(sys_clk), .rst(rst),
      .sl_valid(sl_valid), .sl_write(sl_write), .sl_addr(sl_addr), .sl_lanes(sl_lanes),
      .sl_wdata(sl_wdata), .stall(stall), .sl_done(sl_done), .sl_rdata(sl_rdata));

   // ****************************************************************
   // checking and bus tasks
   // ****************************************************************
   task automatic close_out;
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_flag(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask

   // one request, held over the taking edge, then wait for the answer
   task automatic access(input logic f, x, w, input samd_size_t sz, input logic [31:0] a, d);
      int n;
      req_fetch = f;
      req_exec = x;
      req_write = w;
      req_size = sz;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      saw_sl = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 50) begin
         if (sl_valid === 1'b1 && !saw_sl) begin
            saw_sl = 1'b1;
            got_sel = 32'(sl_sel);
            got_mt = 32'(sl_mtype);
            got_xn = sl_xn;
            got_buf = sl_bufferable;
            got_ln = 32'(sl_lanes);
            got_saddr = sl_addr;
            got_wr = sl_write;
            got_wd = sl_wdata;
         end
         @(posedge sys_clk);
         #1 n++;
      end
      chk_flag("answer", 1'b1, rsp_valid);
      got_fault = rsp_fault;
      got_xnf = rsp_xn_fault;
      got_rd = rsp_rdata;
      // let an edge pass so the next request never meets this one's release
      @(posedge sys_clk);
      #1;
   endtask

   // ****************************************************************
   // clock, reset, watchdog
   // ****************************************************************
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_fetch = 1'b0;
      req_exec = 1'b0;
      req_write = 1'b0;
      req_size = SAMD_SZ_WORD;
      req_addr = 32'h0;
      req_wdata = 32'h0;
      stall = 2'h0;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'b0;
      chk_flag("ready_after_reset", 1'b1, req_ready);
      chk_flag("sl_valid_after_reset", 1'b0, sl_valid);
      // table of plain accesses, issued back to back
      foreach (rows[i]) begin
         r = rows[i];
         access(r.f, r.x, r.w, samd_size_t'(r.sz), r.a, 32'h0000_00AB);
         chk_flag("fault", r.flt, got_fault);
         chk_flag("xn_fault", r.xnf, got_xnf);
         chk_flag("slave_seen", !r.flt, saw_sl);
         if (!r.flt) begin
            chk_val("sel", 32'(r.sel), got_sel);
            chk_val("mtype", 32'(r.mt), got_mt);
            chk_flag("xn", r.xn, got_xn);
            chk_flag("bufferable", r.mt != 2'h2, got_buf);
            chk_val("lanes", 32'(r.ln), got_ln);
            chk_flag("sl_write", r.w, got_wr);
            if (r.w) begin
               chk_val("wdata", r.sz == 2'h0 ? 32'hABAB_ABAB : 32'hAB, got_wd);
            end
         end
      end
      // data steering of narrow reads
      access(0, 0, 0, SAMD_SZ_BYTE, 32'h2000_0009, 32'h0);
      chk_val("byte_rdata", 32'h0012_3456, got_rd);
      access(0, 0, 0, SAMD_SZ_HALF, 32'h2000_000E, 32'h0);
      chk_val("half_rdata", 32'h0000_1234, got_rd);
      // sram alias with a slow slave: set, read back, clear
      stall = 2'h2;
      access(0, 0, 1, SAMD_SZ_WORD, 32'h2200_0020, 32'h0000_0001);
      chk_val("alias_target", 32'h2000_0000, got_saddr);
      access(0, 0, 0, SAMD_SZ_WORD, 32'h2200_0020, 32'h0);
      chk_val("alias_read_set", 32'h0000_0001, got_rd);
      access(0, 0, 0, SAMD_SZ_WORD, 32'h2000_0000, 32'h0);
      chk_val("sram_after_set", 32'h1234_5700, got_rd);
      access(0, 0, 1, SAMD_SZ_WORD, 32'h2200_0020, 32'h0000_000E);
      access(0, 0, 0, SAMD_SZ_WORD, 32'h2200_0020, 32'h0);
      chk_val("alias_read_clr", 32'h0000_0000, got_rd);
      access(0, 0, 0, SAMD_SZ_WORD, 32'h2000_0000, 32'h0);
      chk_val("sram_after_clr", 32'h1234_5600, got_rd);
      // peripheral alias: byte 4 bit 1
      stall = 2'h1;
      access(0, 0, 1, SAMD_SZ_WORD, 32'h4200_0084, 32'h0000_00FF);
      chk_val("palias_target", 32'h4000_0004, got_saddr);
      chk_val("palias_mtype", 32'h1, got_mt);
      access(0, 0, 0, SAMD_SZ_WORD, 32'h4000_0004, 32'h0);
      chk_val("peri_after_set", 32'h1234_5603, got_rd);
      // reset while a slow read is with the slave
      stall = 2'h2;
      req_addr = SAMD_SRAM_BASE;
      req_write = 1'b0;
      req_valid = 1'b1;
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      rst = 1'b1;
      @(posedge sys_clk);
      #1 rst = 1'b0;
      chk_flag("sl_valid_mid_reset", 1'b0, sl_valid);
      chk_flag("ready_mid_reset", 1'b1, req_ready);
      chk_val("rdata_mid_reset", 32'h0, rsp_rdata);
      access(0, 0, 0, SAMD_SZ_WORD, 32'h4000_0004, 32'h0);
      chk_val("peri_after_reset", 32'h1234_5601, got_rd);
      close_out();
   end
endmodule
